/* rtl/jsb_pkg.sv */
// Constants shared by the test-link byte stream bridge.
package jsb_pkg;
  // Link frame: 4-bit command then 8-bit data, least significant bit first.
  localparam int FRAME_BITS = 12;
  localparam logic [3:0] FRAME_LAST = 4'hb;
  localparam int CMD_LSB = 0;
  localparam int DAT_LSB = 4;
  // Command codes carried in the low nibble of a frame.
  localparam logic [3:0] CMD_NOP = 4'h0;
  localparam logic [3:0] CMD_SEND = 4'h1;
  localparam logic [3:0] CMD_RECV = 4'h2;
  localparam logic [3:0] CMD_LOOP = 4'h3;
  localparam logic [3:0] CMD_RESET = 4'h4;
  localparam logic [3:0] CMD_SMP_CLK = 4'h5;
  localparam logic [3:0] CMD_SMP_RST = 4'h6;
  localparam logic [3:0] CMD_SENSE = 4'h7;
  // Reply word: bit 8 marks a valid answer, bits 7:0 carry the byte.
  localparam int RESP_VALID = 8;
  localparam logic [8:0] RESP_RST = 9'h000;
  localparam logic [8:0] RESP_BUSY = 9'h000;
  // Reset request length: at least one second at the system clock.
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int RESET_HOLD_MS = 1000;
  localparam int RESET_CYCLES = (RESET_HOLD_MS * 1000000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int RST_CNT_W = 27;
endpackage

/* rtl/jsb_bridge.sv */
// Bridge between a serial test link and an 8-bit byte source and sink.
`timescale 1ns/1ns

// Overview of operation
// - Only the sink port is throttled by ready.
// - One 8-bit symbol per port transfer.
// - Sent bytes leave the source in order.
// - Sink bytes reach the host in order.
// - Loop command echoes bytes through a register.
// - Reset command holds reset request one second.
// - Clock sample command captures clock once.
// - Reset sample command captures reset once.
// - Sense command sets flag on clock edge.
module jsb_bridge import jsb_pkg::*; #(
  parameter int RESET_LEN = RESET_CYCLES // Reset request length in cycles.
) (
  input wire logic MCLK, // System clock.
  input wire logic SYS_RST, // Synchronous reset, active high.
  input wire logic TCK, // Link clock.
  input wire logic LINK_RST, // Link-side reset, synchronous to TCK.
  input wire logic TSEL, // High while a frame is shifted.
  input wire logic TDI, // Serial data from the host.
  output logic TDO, // Serial reply to the host.
  output logic [7:0] SRC_DATA, // Byte from the host.
  output logic SRC_VALID, // Source byte strobe.
  input wire logic [7:0] SNK_DATA, // Byte bound for the host.
  input wire logic SNK_VALID, // Sink byte offered.
  output logic SNK_READY, // Sink can take a byte.
  output logic RST_REQ // Reset request to the system.
);

  // Link-side state.
  logic [11:0] sh_q;
  logic [11:0] sh_d;
  logic [3:0] cnt_q;
  logic [11:0] out_q;
  logic req_q;
  logic [3:0] cmd_q;
  logic [7:0] dat_q;
  logic ack_s1_q;
  logic ack_s2_q;
  logic mck_s1_q;
  logic mck_s2_q;
  logic rst_s1_q;
  logic rst_s2_q;
  logic [8:0] loc_q;
  logic loc_sel_q;
  // System-side state.
  logic rq_s1_q;
  logic rq_s2_q;
  logic rq_s3_q;
  logic ack_q;
  logic [8:0] resp_q;
  logic [7:0] hold_q;
  logic hold_v_q;
  logic snk_rdy_q;
  logic [7:0] src_q;
  logic src_v_q;
  logic [RST_CNT_W-1:0] rcnt_q;
  logic rreq_q;
  logic sense_q;

  // Frame decode on the link side.
  wire frame_end = TSEL && (cnt_q == FRAME_LAST);
  wire [3:0] f_cmd = sh_d[CMD_LSB +: 4];
  wire [7:0] f_dat = sh_d[DAT_LSB +: 8];
  wire idle = (ack_s2_q == req_q);
  wire is_smp = (f_cmd == CMD_SMP_CLK) || (f_cmd == CMD_SMP_RST);
  wire [8:0] reply = loc_sel_q ? loc_q : (idle ? resp_q : RESP_BUSY);
  assign sh_d = {TDI, sh_q[11:1]};

  // Clock and reset levels and the acknowledge toggle seen from the link side.
  always_ff @(posedge TCK) begin
    mck_s1_q <= MCLK;
    mck_s2_q <= mck_s1_q;
    rst_s1_q <= SYS_RST;
    rst_s2_q <= rst_s1_q;
    ack_s1_q <= ack_q;
    ack_s2_q <= ack_s1_q;
  end

  // Shift in the frame and count its bits.
  always_ff @(posedge TCK) begin
    if (LINK_RST) begin
      sh_q <= 12'h000;
      cnt_q <= 4'h0;
    end else if (TSEL) begin
      sh_q <= sh_d;
      cnt_q <= frame_end ? 4'h0 : cnt_q + 4'h1;
    end else begin
      cnt_q <= 4'h0;
    end
  end

  // Reply shifts out during a frame and reloads between frames.
  always_ff @(posedge TCK) begin
    if (LINK_RST) begin
      out_q <= 12'h000;
    end else if (TSEL) begin
      out_q <= {1'b0, out_q[11:1]};
    end else begin
      out_q <= {3'h0, reply};
    end
  end

  // Completed frames, except samples and frames while busy, issue one request per toggle.
  always_ff @(posedge TCK) begin
    if (LINK_RST) begin
      req_q <= 1'b0;
      cmd_q <= CMD_NOP;
      dat_q <= 8'h00;
      loc_q <= RESP_RST;
      loc_sel_q <= 1'b1;
    end else if (frame_end) begin
      if (is_smp) begin
        loc_q <= {1'b1, 7'h00, (f_cmd == CMD_SMP_CLK) ? mck_s2_q : rst_s2_q};
        loc_sel_q <= 1'b1;
      end else if (!idle) begin
        loc_q <= RESP_BUSY;
        loc_sel_q <= 1'b1;
      end else begin
        req_q <= ~req_q;
        cmd_q <= f_cmd;
        dat_q <= f_dat;
        loc_sel_q <= 1'b0;
      end
    end
  end

  // TDO is registered: out_q[1] during a frame, reply bit 0 between frames.
  always_ff @(posedge TCK) begin
    if (LINK_RST) begin
      TDO <= 1'b0;
    end else begin
      TDO <= TSEL ? out_q[1] : reply[0];
    end
  end

  // Request toggle brought into the system domain.
  // The chain keeps running through a system reset, so a reset never makes an old toggle look new.
  // A reset that cleared it would replay the last command, and a repeated send duplicates a byte.
  always_ff @(posedge MCLK) begin
    rq_s1_q <= req_q;
    rq_s2_q <= rq_s1_q;
    rq_s3_q <= rq_s2_q;
  end

  // Command held stable by the link side while the toggle is open.
  wire evt = (rq_s2_q != rq_s3_q);
  wire do_send = evt && (cmd_q == CMD_SEND);
  wire do_recv = evt && (cmd_q == CMD_RECV);
  wire do_loop = evt && (cmd_q == CMD_LOOP);
  wire do_rst = evt && (cmd_q == CMD_RESET);
  wire do_sense = evt && (cmd_q == CMD_SENSE);
  wire snk_take = SNK_VALID && snk_rdy_q;

  // Execute the command and return its answer.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      ack_q <= rq_s2_q;
      resp_q <= RESP_RST;
    end else if (evt) begin
      ack_q <= rq_s2_q;
      if (do_recv) begin
        resp_q <= {hold_v_q, hold_q};
      end else if (do_loop) begin
        resp_q <= {1'b1, dat_q};
      end else if (do_sense) begin
        resp_q <= {1'b1, 8'h01};
      end else begin
        resp_q <= {1'b1, 8'h00};
      end
    end
  end

  // Source port: one strobe per send, no ready.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      src_q <= 8'h00;
      src_v_q <= 1'b0;
    end else begin
      src_v_q <= do_send;
      if (do_send) begin
        src_q <= dat_q;
      end
    end
  end

  // Sink port: a one-byte holding register gated by ready.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      hold_q <= 8'h00;
      hold_v_q <= 1'b0;
      snk_rdy_q <= 1'b0;
    end else if (snk_take) begin
      hold_q <= SNK_DATA;
      hold_v_q <= 1'b1;
      snk_rdy_q <= 1'b0;
    end else if (do_recv || !hold_v_q) begin
      hold_v_q <= 1'b0;
      snk_rdy_q <= 1'b1;
    end
  end

  // Reset request counter.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rcnt_q <= '0;
      rreq_q <= 1'b0;
    end else if (do_rst) begin
      rcnt_q <= RST_CNT_W'(RESET_LEN - 1);
      rreq_q <= 1'b1;
    end else if (rcnt_q != '0) begin
      rcnt_q <= rcnt_q - 1'b1;
    end else begin
      rreq_q <= 1'b0;
    end
  end

  // Sense flag set on a rising system clock edge.
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      sense_q <= 1'b0;
    end else if (do_sense) begin
      sense_q <= 1'b1;
    end
  end

  // Outputs driven by registers.
  assign SRC_DATA = src_q;
  assign SRC_VALID = src_v_q;
  assign SNK_READY = snk_rdy_q;
  assign RST_REQ = rreq_q;

  // Checks on the system side.
  chk_src_single: assert property (@(posedge MCLK) disable iff (SYS_RST)
    src_v_q |=> !src_v_q && $stable(src_q))
    else $error("source strobe longer than one cycle");

  chk_send_byte: assert property (@(posedge MCLK) disable iff (SYS_RST)
    do_send |=> src_v_q && (src_q == $past(dat_q)))
    else $error("sent byte not presented");

  chk_sink_capture: assert property (@(posedge MCLK) disable iff (SYS_RST)
    snk_take |=> hold_v_q && !snk_rdy_q && (hold_q == $past(SNK_DATA)))
    else $error("sink byte not held");

  chk_recv_reply: assert property (@(posedge MCLK) disable iff (SYS_RST)
    do_recv |=> resp_q == {$past(hold_v_q), $past(hold_q)})
    else $error("received byte out of order");

  chk_loop_echo: assert property (@(posedge MCLK) disable iff (SYS_RST)
    do_loop |=> resp_q == {1'b1, $past(dat_q)})
    else $error("loop byte not echoed");

  chk_reset_hold: assert property (@(posedge MCLK) disable iff (SYS_RST)
    do_rst |=> rreq_q [*8])
    else $error("reset request dropped early");

  chk_reset_count: assert property (@(posedge MCLK) disable iff (SYS_RST)
    $fell(rreq_q) |-> $past(rcnt_q) == '0)
    else $error("reset request ended before count");

  chk_sense_flag: assert property (@(posedge MCLK) disable iff (SYS_RST)
    do_sense |=> sense_q && resp_q == {1'b1, 8'h01})
    else $error("sense flag not set");

  chk_ack_close: assert property (@(posedge MCLK) disable iff (SYS_RST)
    evt |=> (ack_q == rq_s3_q) && !evt)
    else $error("handshake not closed");

  // Checks on the link side.
  chk_clk_sample: assert property (@(posedge TCK) disable iff (LINK_RST)
    frame_end && (f_cmd == CMD_SMP_CLK) |=> loc_sel_q && loc_q == {1'b1, 7'h00, $past(mck_s2_q)})
    else $error("clock level not captured");

  chk_rst_sample: assert property (@(posedge TCK) disable iff (LINK_RST)
    frame_end && (f_cmd == CMD_SMP_RST) |=> loc_sel_q && loc_q == {1'b1, 7'h00, $past(rst_s2_q)})
    else $error("reset level not captured");

  chk_req_once: assert property (@(posedge TCK) disable iff (LINK_RST)
    frame_end && !idle |=> $stable(req_q))
    else $error("request issued while busy");

  // Main scenarios.
  cov_send: cover property (@(posedge MCLK) disable iff (SYS_RST) do_send);
  cov_recv_byte: cover property (@(posedge MCLK) disable iff (SYS_RST) do_recv && hold_v_q);
  cov_reset: cover property (@(posedge MCLK) disable iff (SYS_RST) $fell(rreq_q));
  cov_busy: cover property (@(posedge TCK) disable iff (LINK_RST) frame_end && !idle);

endmodule

/* verification/stream_partner.sv */
// System-side model that takes source bytes and offers sink bytes.
`timescale 1ns/1ns
module stream_partner (
  input wire logic MCLK, // System clock.
  input wire logic SYS_RST, // System reset, active high.
  input wire logic [7:0] SRC_DATA, // Byte from the bridge.
  input wire logic SRC_VALID, // Source strobe.
  input wire logic SNK_READY, // Bridge can take a byte.
  output logic [7:0] SNK_DATA, // Byte offered to the bridge.
  output logic SNK_VALID // Offer is valid.
);
  logic [7:0] tx_q[$];
  logic [7:0] rx_q[$];
  logic took = 1'b0;
  initial begin
    SNK_DATA = 8'h00;
    SNK_VALID = 1'b0;
  end
  // Every strobe is taken whole, since the source cannot be held off.
  // unthrottled byte capture
  always @(posedge MCLK) begin
    if (SRC_VALID) begin
      rx_q.push_back(SRC_DATA);
    end
    took = SNK_VALID && SNK_READY;
  end
  // An offer is held until taken; an idle data bus toggles every cycle.
  // hold until ready
  always @(negedge MCLK) begin
    if (took) begin
      void'(tx_q.pop_front());
    end
    SNK_VALID = (tx_q.size() > 0) && !SYS_RST;
    SNK_DATA = SNK_VALID ? tx_q[0] : ~SNK_DATA;
  end
endmodule

/* verification/tb.sv */
// Self-checking bench for the link byte stream bridge.
`timescale 1ns/1ns
module tb;
  import jsb_pkg::*;
  localparam int RLEN = 20;
  logic mclk = 1'b0, tck = 1'b0, sys_rst = 1'b1, link_rst = 1'b1, tsel = 1'b0, tdi = 1'b0, mclk_run = 1'b1;
  logic tdo, src_valid, snk_valid, snk_ready, rst_req;
  logic [7:0] src_data, snk_data;
  logic [11:0] rep;
  int errors = 0, samples_checked = 0, cycles = 0, hi_cnt = 0;
  jsb_bridge #(.RESET_LEN(RLEN)) uut (.MCLK(mclk), .SYS_RST(sys_rst), .TCK(tck), .LINK_RST(link_rst),
    .TSEL(tsel), .TDI(tdi), .TDO(tdo), .SRC_DATA(src_data), .SRC_VALID(src_valid), .SNK_DATA(snk_data),
    .SNK_VALID(snk_valid), .SNK_READY(snk_ready), .RST_REQ(rst_req));
  stream_partner far (.MCLK(mclk), .SYS_RST(sys_rst), .SRC_DATA(src_data), .SRC_VALID(src_valid),
    .SNK_READY(snk_ready), .SNK_DATA(snk_data), .SNK_VALID(snk_valid));
  // System clock, which a test may stop at a chosen level.
  always #5 if (mclk_run) mclk = ~mclk;
  // Link clock, offset so its edges never meet the system clock edges.
  initial begin
    #13;
    forever #40 tck = ~tck;
  end
  // Reset request width counter and hang limit.
  always @(negedge mclk) if (rst_req) hi_cnt++;
  always @(posedge tck) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [11:0] got, input logic [11:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  // Shifts one frame in and collects the previous reply from the serial output.
  task automatic frame(input logic [3:0] cmd, input logic [7:0] dat);
    logic [11:0] w;
    w = {dat, cmd};
    for (int i = 0; i < 12; i++) begin
      @(negedge tck);
      rep[i] = tdo;
      tsel = 1'b1;
      tdi = w[i];
    end
    @(negedge tck);
    tsel = 1'b0;
    tdi = ~tdi;
    repeat (20) @(negedge tck);
  endtask
  task automatic ask(input logic [3:0] cmd, input logic [7:0] dat);
    frame(cmd, dat);
    frame(CMD_NOP, 8'h00);
  endtask
  task automatic test_send;
    logic [7:0] v[4] = '{8'ha5, 8'h3c, 8'hff, 8'h00};
    foreach (v[i]) frame(CMD_SEND, v[i]);
    check(12'(far.rx_q.size()), 12'h004, "source count");
    foreach (v[i]) check({4'h0, far.rx_q[i]}, {4'h0, v[i]}, "source order");
    $display("test_send done");
  endtask
  task automatic test_recv;
    logic [7:0] v[3] = '{8'h11, 8'h22, 8'h33};
    foreach (v[i]) far.tx_q.push_back(v[i]);
    repeat (2) @(negedge tck);
    check({11'h000, snk_ready}, 12'h000, "sink held off");
    foreach (v[i]) begin
      ask(CMD_RECV, 8'h00);
      check(rep, {4'h1, v[i]}, "sink order");
    end
    ask(CMD_RECV, 8'h00);
    check({11'h000, rep[RESP_VALID]}, 12'h000, "empty holder");
    $display("test_recv done");
  endtask
  task automatic test_loop;
    logic [7:0] v[3] = '{8'h00, 8'h5a, 8'hff};
    foreach (v[i]) begin
      ask(CMD_LOOP, v[i]);
      check(rep, {4'h1, v[i]}, "loop echo");
    end
    $display("test_loop done");
  endtask
  task automatic test_reset;
    hi_cnt = 0;
    ask(CMD_RESET, 8'h00);
    check(12'(hi_cnt), 12'(RLEN), "reset request width");
    check({11'h000, rst_req}, 12'h000, "reset request end");
    $display("test_reset done");
  endtask
  task automatic test_sample;
    @(posedge mclk);
    mclk_run = 1'b0;
    ask(CMD_SMP_CLK, 8'h00);
    check(rep, 12'h101, "clock high sample");
    mclk_run = 1'b1;
    @(negedge mclk);
    mclk_run = 1'b0;
    ask(CMD_SMP_CLK, 8'h00);
    check(rep, 12'h100, "clock low sample");
    mclk_run = 1'b1;
    ask(CMD_SENSE, 8'h00);
    check(rep, 12'h101, "clock sense");
    // Two sends leave a send as the last command and a raised toggle level when reset comes.
    frame(CMD_SEND, 8'h77);
    frame(CMD_SEND, 8'h78);
    @(negedge mclk);
    sys_rst = 1'b1;
    ask(CMD_SMP_RST, 8'h00);
    check(rep, 12'h101, "reset high sample");
    @(negedge mclk);
    sys_rst = 1'b0;
    ask(CMD_SMP_RST, 8'h00);
    check(rep, 12'h100, "reset low sample");
    check(12'(far.rx_q.size()), 12'h006, "no repeat after reset");
    check({4'h0, far.rx_q[5]}, 12'h078, "last sent byte");
    $display("test_sample done");
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // Main sequence: system reset released first, then link reset, then each test in turn.
  initial begin
    repeat (20) @(negedge mclk);
    repeat (3) @(negedge tck);
    @(negedge mclk);
    sys_rst = 1'b0;
    @(negedge tck);
    link_rst = 1'b0;
    repeat (4) @(negedge tck);
    test_send();
    test_recv();
    test_loop();
    test_reset();
    test_sample();
    give_verdict();
  end
endmodule
